// ### verilog/swap_skip_pkg.sv
// Purpose: Shared constants and types for the swap/skip/table/xor unit
// Assumes: 32-bit classic Wishbone register access, 100 MHz clock
// Notes:   Register offsets are byte addresses of aligned words
package swap_skip_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ROM_W = 14;
    localparam int ROM_ADR_W = 11;
    localparam int PAGE_W = 3;
    localparam int DMEM_ADR_W = 7;
    localparam int DMEM_DEPTH = 96;
    localparam int TABLE_HIGH_REGISTER_W = ROM_W - DATA_W;
    localparam int WB_ADR_W = 5;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [WB_ADR_W-1:0] OFS_INSTR = 5'h00;
    localparam logic [WB_ADR_W-1:0] OFS_ACC = 5'h04;
    localparam logic [WB_ADR_W-1:0] OFS_TABLE_POINTER = 5'h08;
    localparam logic [WB_ADR_W-1:0] OFS_TABLE_HIGH_REGISTER = 5'h0C;
    localparam logic [WB_ADR_W-1:0] OFS_STATUS = 5'h10;
    localparam logic [WB_ADR_W-1:0] OFS_PAGE = 5'h14;
    localparam logic [WB_ADR_W-1:0] OFS_DADR = 5'h18;
    localparam logic [WB_ADR_W-1:0] OFS_DDAT = 5'h1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int INS_OP_LSB = 0;
    localparam int INS_BIT_LSB = 4;
    localparam int INS_ADR_LSB = 8;
    localparam int INS_IMM_LSB = 16;
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_SKIP_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values and fixed pages
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [TABLE_HIGH_REGISTER_W-1:0] TABLE_HIGH_REGISTER_RST = 6'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Opcodes and states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_NIBBLE_SWAP_TO_ACC = 4'h1,
        OP_SKIP_WHEN_ZERO = 4'h2,
        OP_LOAD_ACC_SKIP_WHEN_ZERO = 4'h3,
        OP_SKIP_BIT_ZERO = 4'h4,
        OP_TABLE_READ_CURRENT_PAGE = 4'h5,
        OP_TABLE_READ_LAST_PAGE = 4'h6,
        OP_XOR_ACC_MEM = 4'h7,
        OP_EXCLUSIVE_OR_TO_MEMORY = 4'h8,
        OP_XOR_IMM = 4'h9
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROM_WAIT = 2'b01,
        ST_DUMMY = 2'b10
    } state_e;

    typedef struct packed {
        logic [DATA_W-1:0] imm;
        logic [DMEM_ADR_W-1:0] addr;
        logic [2:0] bit_sel;
        logic [3:0] opcode;
    } instr_s;

    typedef struct packed {
        logic rd;
        logic [ROM_ADR_W-1:0] addr;
    } rom_req_s;

endpackage : swap_skip_pkg

// ### verilog/swap_skip_tableread_xor_ops.sv
// Purpose: Executes swap, skip, table read and xor instructions
// Assumes: Issued by writing the instruction register over Wishbone
// Notes:   Program memory answers in the cycle its read strobe is high
//          Writes while busy are acknowledged and dropped
//          Table reads and taken skips keep it busy one cycle
//          Data memory keeps its contents through reset
//
// Summary of operation
// (RULE_01) Swap nibbles of byte into accumulator
// (RULE_02) Skip next instruction when byte is zero
// (RULE_03) Skip discards prefetch, adds one dummy cycle
// (RULE_04) Load byte to accumulator, skip if zero
// (RULE_05) Skip next when selected bit is zero
// (RULE_06) Current page table read to memory, high
// (RULE_07) Last page table read to memory, high
// (RULE_08) Xor memory into accumulator, zero flag only
// (RULE_09) Xor accumulator into memory, zero flag only
// (RULE_10) Xor immediate into accumulator, zero flag only
// (RULE_11) Page from program counter; last page highest (here the current page is the software-written page_r, not a program counter)
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps

module swap_skip_tableread_xor_ops (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [swap_skip_pkg::WB_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output swap_skip_pkg::rom_req_s rom_req_out,
    input wire logic [swap_skip_pkg::ROM_W-1:0] rom_data_in,
    output logic skip_out
);
    import swap_skip_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    state_e state_r;
    state_e state_nxt;
    logic [DATA_W-1:0] accumulator_r;
    logic [DATA_W-1:0] accumulator_nxt;
    logic [DATA_W-1:0] table_pointer_r;
    logic [TABLE_HIGH_REGISTER_W-1:0] table_high_register_r;
    logic [PAGE_W-1:0] page_r;
    logic [DMEM_ADR_W-1:0] dadr_r;
    logic [DMEM_ADR_W-1:0] dest_r;
    logic zero_r;
    logic zero_nxt;
    logic skip_r;
    logic ack_r;
    logic [31:0] rd_dat_r;
    rom_req_s rom_req_r;
    rom_req_s rom_req_nxt;
    logic [DATA_W-1:0] dmem [0:DMEM_DEPTH-1];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire bus_req = wb_cyc_in & wb_stb_in;
    wire bus_fire = bus_req & ack_r;
    wire wr_fire = bus_fire & wb_we_in & wb_sel_in[0];
    wire idle = (state_r == ST_IDLE);
    wire hit_instr = (wb_adr_in == OFS_INSTR);
    wire hit_acc = (wb_adr_in == OFS_ACC);
    wire hit_table_pointer = (wb_adr_in == OFS_TABLE_POINTER);
    wire hit_table_high_register = (wb_adr_in == OFS_TABLE_HIGH_REGISTER);
    wire hit_status = (wb_adr_in == OFS_STATUS);
    wire hit_page = (wb_adr_in == OFS_PAGE);
    wire hit_dadr = (wb_adr_in == OFS_DADR);
    wire hit_ddat = (wb_adr_in == OFS_DDAT);
    wire wr_ok = wr_fire & idle;
    wire go = wr_ok & hit_instr;
    // (RULE_06) Program word being taken
    wire in_rom = (state_r == ST_ROM_WAIT);
    // (RULE_03) Dummy cycle in progress
    wire in_dummy = (state_r == ST_DUMMY);

    // ----------------------------------------------------------------
    // Instruction fields
    // ----------------------------------------------------------------
    instr_s ins;
    assign ins.opcode = wb_dat_in[INS_OP_LSB +: 4];
    // (RULE_05) Bit select field
    assign ins.bit_sel = wb_dat_in[INS_BIT_LSB +: 3];
    assign ins.addr = wb_dat_in[INS_ADR_LSB +: DMEM_ADR_W];
    // (RULE_10) Immediate operand field
    assign ins.imm = wb_dat_in[INS_IMM_LSB +: DATA_W];

    wire ins_adr_ok = (32'(ins.addr) < DMEM_DEPTH);
    wire [DATA_W-1:0] m_byte = ins_adr_ok ? dmem[ins.addr] : BYTE_ZERO;
    // (RULE_02) Zero byte compare
    wire m_is_zero = (m_byte == BYTE_ZERO);
    wire m_bit = m_byte[ins.bit_sel];
    // (RULE_08) Accumulator xor memory
    wire [DATA_W-1:0] xor_mem = accumulator_r ^ m_byte;
    // (RULE_10) Accumulator xor immediate
    wire [DATA_W-1:0] xor_imm = accumulator_r ^ ins.imm;
    wire dadr_ok = (32'(dadr_r) < DMEM_DEPTH);
    wire [DATA_W-1:0] d_byte = dadr_ok ? dmem[dadr_r] : BYTE_ZERO;
    wire dest_ok = (32'(dest_r) < DMEM_DEPTH);

    // ----------------------------------------------------------------
    // Nibble swap
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] swapped;

    // (RULE_01) Halves exchanged per bit
    for (genvar gi = 0; gi < DATA_W; gi++) begin : g_swap
        assign swapped[gi] = m_byte[(gi + DATA_W / 2) % DATA_W];
    end

    // ----------------------------------------------------------------
    // Execute decode
    // ----------------------------------------------------------------
    logic skip_cond;
    logic mem_we;
    logic [DMEM_ADR_W-1:0] mem_adr;
    logic [DATA_W-1:0] mem_dat;
    wire skip_go = go & skip_cond;

    always_comb begin
        state_nxt = state_r;
        accumulator_nxt = accumulator_r;
        zero_nxt = zero_r;
        skip_cond = 1'b0;
        rom_req_nxt.rd = 1'b0;
        rom_req_nxt.addr = rom_req_r.addr;
        mem_we = 1'b0;
        mem_adr = dadr_r;
        mem_dat = wb_dat_in[DATA_W-1:0];
        unique case (state_r)
            ST_IDLE: begin
                if (wr_ok & hit_acc) begin
                    accumulator_nxt = wb_dat_in[DATA_W-1:0];
                end
                if (wr_ok & hit_ddat) begin
                    mem_we = dadr_ok;
                end
                if (go) begin
                    unique case (ins.opcode)
                        // (RULE_01) Swapped byte to accumulator
                        OP_NIBBLE_SWAP_TO_ACC: begin
                            accumulator_nxt = swapped;
                        end
                        // (RULE_02) Zero byte test
                        OP_SKIP_WHEN_ZERO: begin
                            skip_cond = m_is_zero;
                        end
                        // (RULE_04) Load and test byte
                        OP_LOAD_ACC_SKIP_WHEN_ZERO: begin
                            accumulator_nxt = m_byte;
                            skip_cond = m_is_zero;
                        end
                        // (RULE_05) Selected bit test
                        OP_SKIP_BIT_ZERO: begin
                            skip_cond = ~m_bit;
                        end
                        // (RULE_06) Current page address
                        // (RULE_11) Page from software page register page_r
                        OP_TABLE_READ_CURRENT_PAGE: begin
                            rom_req_nxt.rd = 1'b1;
                            rom_req_nxt.addr = {page_r, table_pointer_r};
                            state_nxt = ST_ROM_WAIT;
                        end
                        // (RULE_07) Last page address
                        // (RULE_11) Highest page constant
                        OP_TABLE_READ_LAST_PAGE: begin
                            rom_req_nxt.rd = 1'b1;
                            rom_req_nxt.addr = {LAST_PAGE, table_pointer_r};
                            state_nxt = ST_ROM_WAIT;
                        end
                        // (RULE_08) Xor into accumulator
                        OP_XOR_ACC_MEM: begin
                            accumulator_nxt = xor_mem;
                            zero_nxt = (xor_mem == BYTE_ZERO);
                        end
                        // (RULE_09) Xor back into memory
                        OP_EXCLUSIVE_OR_TO_MEMORY: begin
                            mem_we = ins_adr_ok;
                            mem_adr = ins.addr;
                            mem_dat = xor_mem;
                            zero_nxt = (xor_mem == BYTE_ZERO);
                        end
                        // (RULE_10) Xor immediate
                        OP_XOR_IMM: begin
                            accumulator_nxt = xor_imm;
                            zero_nxt = (xor_imm == BYTE_ZERO);
                        end
                        default: begin
                        end
                    endcase
                    // (RULE_03) Skip inserts dummy cycle
                    if (skip_cond) begin
                        state_nxt = ST_DUMMY;
                    end
                end
            end
            ST_ROM_WAIT: begin
                // (RULE_06) Low byte to memory
                // (RULE_07) Low byte to memory
                mem_we = dest_ok;
                mem_adr = dest_r;
                mem_dat = rom_data_in[DATA_W-1:0];
                state_nxt = ST_IDLE;
            end
            ST_DUMMY: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = WORD_ZERO;
        if (hit_acc) begin
            rd_mux[DATA_W-1:0] = accumulator_r;
        end
        if (hit_table_pointer) begin
            rd_mux[DATA_W-1:0] = table_pointer_r;
        end
        if (hit_table_high_register) begin
            rd_mux[TABLE_HIGH_REGISTER_W-1:0] = table_high_register_r;
        end
        if (hit_status) begin
            rd_mux[ST_ZERO_BIT] = zero_r;
            rd_mux[ST_BUSY_BIT] = ~idle;
            rd_mux[ST_SKIP_BIT] = in_dummy;
        end
        if (hit_page) begin
            rd_mux[PAGE_W-1:0] = page_r;
        end
        if (hit_dadr) begin
            rd_mux[DMEM_ADR_W-1:0] = dadr_r;
        end
        if (hit_ddat) begin
            rd_mux[DATA_W-1:0] = d_byte;
        end
    end

    // ----------------------------------------------------------------
    // Bus registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
            rd_dat_r <= WORD_ZERO;
        end else begin
            ack_r <= bus_req & ~ack_r;
            if (bus_req & ~ack_r) begin
                rd_dat_r <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            table_pointer_r <= BYTE_ZERO;
            page_r <= PAGE_RST;
            dadr_r <= DMEM_ADR_W'(0);
        end else if (wr_ok) begin
            if (hit_table_pointer) begin
                table_pointer_r <= wb_dat_in[DATA_W-1:0];
            end
            // (RULE_11) Current page from software
            if (hit_page) begin
                page_r <= wb_dat_in[PAGE_W-1:0];
            end
            if (hit_dadr) begin
                dadr_r <= wb_dat_in[DMEM_ADR_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Execution registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_IDLE;
            accumulator_r <= BYTE_ZERO;
            zero_r <= 1'b0;
            skip_r <= 1'b0;
            rom_req_r <= '0;
            dest_r <= DMEM_ADR_W'(0);
        end else begin
            state_r <= state_nxt;
            accumulator_r <= accumulator_nxt;
            zero_r <= zero_nxt;
            // (RULE_03) Discard pulse for prefetch
            skip_r <= skip_go;
            rom_req_r <= rom_req_nxt;
            if (go) begin
                dest_r <= ins.addr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Table high register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            table_high_register_r <= TABLE_HIGH_REGISTER_RST;
        end else if (in_rom) begin
            // (RULE_06) High part captured
            // (RULE_07) High part captured
            table_high_register_r <= rom_data_in[ROM_W-1:DATA_W];
        end
    end

    // ----------------------------------------------------------------
    // Data memory
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        // (RULE_09) Results written back
        if (mem_we) begin
            dmem[mem_adr] <= mem_dat;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_out = ack_r;
    assign wb_dat_out = rd_dat_r;
    assign rom_req_out = rom_req_r;
    assign skip_out = skip_r;

endmodule : swap_skip_tableread_xor_ops

// ### dv/swap_skip_props.sv
// Purpose: Port checker for the swap/skip/table/xor unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind from the bench top
`timescale 1ns/100ps
module swap_skip_props
    import swap_skip_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [swap_skip_pkg::WB_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire swap_skip_pkg::rom_req_s rom_req_out,
    input wire logic [swap_skip_pkg::ROM_W-1:0] rom_data_in,
    input wire logic skip_out
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic iw = wb_ack_out && wb_we_in && wb_adr_in == OFS_INSTR
        && wb_sel_in[0];
    wire logic [3:0] op = wb_dat_in[3:0];
    wire logic skip_ins = iw && op inside {4'h2, 4'h3, 4'h4};
    wire logic tbl_ins = iw && op inside {4'h5, 4'h6};
    AST_ACK_LAT:
        assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack not one cycle after request");
    AST_SKIP_CAUSE:
        assert property (skip_out |-> $past(skip_ins))
        else $error("skip without a skip instruction");
    AST_SKIP_ONE:
        assert property (skip_out |=> !skip_out)
        else $error("skip longer than one dummy cycle");
    AST_ROM_CAUSE:
        assert property (rom_req_out.rd |-> $past(tbl_ins))
        else $error("program read without table read");
    AST_CUR_ISSUE:
        assert property (iw && op == 4'h5 |=> rom_req_out.rd && !skip_out)
        else $error("current page read not issued");
    AST_LAST_PG:
        assert property (iw && op == 4'h6 |=>
            rom_req_out.rd && rom_req_out.addr[10:8] == LAST_PAGE)
        else $error("last page read not on last page");
    AST_ROM_HOLD:
        assert property (rom_req_out.rd |=>
            !rom_req_out.rd && $stable(rom_req_out.addr))
        else $error("program read strobe or address wrong");
    AST_XOR_QUIET:
        assert property (iw && op inside {4'h1, 4'h7, 4'h8, 4'h9} |=>
            !skip_out && !rom_req_out.rd)
        else $error("xor or swap caused skip or read");
endmodule : swap_skip_props

// ### dv/prog_rom_model.sv
// Purpose: Program memory stand-in for the table read port
// Assumes: Word valid in the cycle the read strobe is high
// Notes:   Out of reset and off the strobe the data lines toggle every cycle
`timescale 1ns/100ps
module prog_rom_model
    import swap_skip_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire swap_skip_pkg::rom_req_s req_in,
    output logic [swap_skip_pkg::ROM_W-1:0] data_out
);
    logic [ROM_W-1:0] last_r;
    wire logic [ROM_W-1:0] word = {req_in.addr[10:5], req_in.addr[7:0]}
        ^ 14'h1A5C;
    assign data_out = req_in.rd ? word : ~last_r;
    always_ff @(posedge ref_clk_in) begin
        last_r <= rst_n_in ? data_out : 14'h0000;
    end
endmodule : prog_rom_model

// ### dv/test_swap_skip_tableread_xor_ops.sv
// Purpose: Self-checking bench for the swap/skip/table/xor unit
// Assumes: Ack one cycle after request, busy one cycle
// Notes:   Program memory is a model in its own file
`timescale 1ns/100ps
module test_swap_skip_tableread_xor_ops;
    import swap_skip_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [WB_ADR_W-1:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = WORD_ZERO;
    logic [31:0] rdat;
    logic ack;
    rom_req_s rreq;
    logic [ROM_W-1:0] rom_data;
    logic skip;
    logic s;
    logic [ROM_W-1:0] w;
    int errors = 0;
    int num_checks = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    swap_skip_tableread_xor_ops DUT (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .rom_req_out(rreq),
        .rom_data_in(rom_data), .skip_out(skip));
    prog_rom_model u_rom (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .req_in(rreq), .data_out(rom_data));
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        if (n >= 16)
            errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic cr(input string nm, input logic [4:0] a,
            input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, WORD_ZERO, q);
        chk(nm, q, e);
    endtask : cr
    task automatic setm(input logic [6:0] a, input logic [7:0] v);
        wr(OFS_DADR, {25'h0, a});
        wr(OFS_DDAT, {24'h00_0000, v});
    endtask : setm
    task automatic mc(input string nm, input logic [6:0] a,
            input logic [7:0] e);
        wr(OFS_DADR, {25'h0, a});
        cr(nm, OFS_DDAT, {24'h00_0000, e});
    endtask : mc
    task automatic ex(input logic [3:0] op, input logic [2:0] b,
            input logic [6:0] a, input logic [7:0] i);
        wr(OFS_INSTR, {8'h00, i, 1'b0, a, 1'b0, b, op});
        @(posedge ref_clk_in);
        s = skip;
    endtask : ex
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int k = 0; k < 7; k++)
            cr("reset reg", 5'(k * 4), WORD_ZERO);
        cr("unmapped", 5'h02, WORD_ZERO);
        setm(7'h60, 8'h55);
        mc("mem 96", 7'h60, 8'h00);
    endtask : t_reset
    task automatic t_swap();
        setm(7'h03, 8'hA5);
        ex(4'h1, 3'h0, 7'h03, 8'h00);
        chk("swap skip", s, 0);
        cr("swap acc", OFS_ACC, 32'h0000_005A);
        mc("swap mem", 7'h03, 8'hA5);
    endtask : t_swap
    task automatic t_skip();
        setm(7'h05, 8'h00);
        ex(4'h2, 3'h0, 7'h05, 8'h00);
        chk("skip zero", s, 1);
        setm(7'h05, 8'h10);
        ex(4'h2, 3'h0, 7'h05, 8'h00);
        chk("skip nonzero", s, 0);
        mc("skip mem", 7'h05, 8'h10);
        wr(OFS_ACC, 32'h0000_0077);
        setm(7'h06, 8'h00);
        ex(4'h3, 3'h0, 7'h06, 8'h00);
        chk("lsz skip", s, 1);
        cr("lsz acc", OFS_ACC, WORD_ZERO);
        setm(7'h06, 8'h80);
        ex(4'h3, 3'h0, 7'h06, 8'h00);
        chk("lsz noskip", s, 0);
        cr("lsz acc2", OFS_ACC, 32'h0000_0080);
    endtask : t_skip
    task automatic t_bit();
        logic [7:0] p;
        p = 8'h6B;
        setm(7'h07, p);
        for (int b = 0; b < 8; b++) begin
            ex(4'h4, 3'(b), 7'h07, 8'h00);
            chk("bit skip", s, !p[b]);
        end
    endtask : t_bit
    task automatic t_tbl();
        wr(OFS_PAGE, 32'h0000_0003);
        wr(OFS_TABLE_POINTER, 32'h0000_004B);
        ex(4'h5, 3'h0, 7'h09, 8'h00);
        w = {3'h3, 3'h2, 8'h4B} ^ 14'h1A5C;
        mc("tbl cur low", 7'h09, w[7:0]);
        cr("tbl cur high", OFS_TABLE_HIGH_REGISTER, {26'h0, w[13:8]});
        wr(OFS_TABLE_POINTER, 32'h0000_00C1);
        ex(4'h6, 3'h0, 7'h0A, 8'h00);
        w = {3'h7, 3'h6, 8'hC1} ^ 14'h1A5C;
        chk("tbl skip", s, 0);
        mc("tbl last low", 7'h0A, w[7:0]);
        cr("tbl last high", OFS_TABLE_HIGH_REGISTER, {26'h0, w[13:8]});
    endtask : t_tbl
    task automatic t_xor();
        wr(OFS_ACC, 32'h0000_003C);
        setm(7'h0B, 8'h3C);
        ex(4'h7, 3'h0, 7'h0B, 8'h00);
        cr("xor acc", OFS_ACC, WORD_ZERO);
        cr("xor zero", OFS_STATUS, 32'h0000_0001);
        ex(4'h1, 3'h0, 7'h0B, 8'h00);
        cr("swap flag", OFS_STATUS, 32'h0000_0001);
        ex(4'h9, 3'h0, 7'h00, 8'hFF);
        cr("imm acc", OFS_ACC, 32'h0000_003C);
        cr("imm zero", OFS_STATUS, WORD_ZERO);
        setm(7'h0C, 8'h3C);
        ex(4'h8, 3'h0, 7'h0C, 8'h00);
        mc("exclusive_or_to_memory mem", 7'h0C, 8'h00);
        cr("exclusive_or_to_memory acc", OFS_ACC, 32'h0000_003C);
        cr("exclusive_or_to_memory zero", OFS_STATUS, 32'h0000_0001);
        setm(7'h0D, 8'h01);
        ex(4'h2, 3'h0, 7'h0D, 8'h00);
        cr("skip flag", OFS_STATUS, 32'h0000_0001);
        ex(4'h3, 3'h0, 7'h0D, 8'h00);
        cr("lsz flag", OFS_STATUS, 32'h0000_0001);
        ex(4'h4, 3'h1, 7'h0D, 8'h00);
        chk("bit flag skip", s, 1);
        cr("bit flag", OFS_STATUS, 32'h0000_0001);
        ex(4'h5, 3'h0, 7'h0E, 8'h00);
        cr("tbl cur flag", OFS_STATUS, 32'h0000_0001);
        ex(4'h6, 3'h0, 7'h0E, 8'h00);
        cr("tbl last flag", OFS_STATUS, 32'h0000_0001);
        ex(4'hF, 3'h0, 7'h0D, 8'h55);
        chk("nop skip", s, 0);
        cr("nop acc", OFS_ACC, 32'h0000_0001);
    endtask : t_xor
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_swap();
        t_skip();
        t_bit();
        t_tbl();
        t_xor();
        tally_and_finish();
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : test_swap_skip_tableread_xor_ops
bind swap_skip_tableread_xor_ops swap_skip_props u_props (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .rom_req_out(rom_req_out),
    .rom_data_in(rom_data_in), .skip_out(skip_out));
